// ==== hw/mrs_pkg.sv ====
package mrs_pkg;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 6;
	localparam int SADDR_W = 4;
	localparam logic [3:0] SADDR_MIN = 4'h7;
	localparam logic [7:0] WREG_RST = 8'h00;
	localparam logic DEST_WREG = 1'b0;
	localparam logic [2:0] FLAGS_RST = 3'h0;
	localparam logic [7:0] FWD_RST = 8'h00;
	localparam logic TO_RST = 1'b1;
	localparam logic PD_RST = 1'b1;

	typedef enum logic [2:0] {
		MRS_OP_NONE = 3'h0,
		MRS_OP_RRC = 3'h1,
		MRS_OP_SBI = 3'h3,
		MRS_OP_SBF = 3'h2,
		MRS_OP_AUX = 3'h6,
		MRS_OP_HALT = 3'h7
	} mrs_op_e;

	typedef struct packed {
		mrs_op_e op;
		logic dest;
		logic [7:0] imm;
	} mrs_cmd_s;

	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} mrs_flags_s;
endpackage : mrs_pkg

// ==== hw/mrs_exec.sv ====
`timescale 1ns/1ps
module mrs_exec (
	// Clock and reset.
	input wire logic clock,
	input wire logic srst,
	// Instruction issue.
	input wire logic cmd_valid,
	input wire mrs_pkg::mrs_cmd_s cmd,
	// Operands from the file bank and auxiliary page.
	input wire logic [7:0] file_rdata,
	input wire logic [7:0] aux_rdata,
	input wire logic [3:0] aux_addr,
	// Results.
	output logic [7:0] working_register,
	output mrs_pkg::mrs_flags_s flags,
	output logic file_we,
	output logic [7:0] file_wdata,
	output logic wdt_clear,
	output logic halt_mode,
	output logic timeout_status_flag,
	output logic powerdown_status_flag
);
	logic [7:0] wreg_ff;
	mrs_pkg::mrs_flags_s flags_ff;
	logic fwe_ff;
	logic [7:0] fwd_ff;
	logic wclr_ff;
	logic halt_ff;
	logic to_ff;
	logic pd_ff;
	logic [7:0] sb_res_q;

	// One decoder for every instruction compare, so the issue qualifier
	// cannot drift between the datapath and the checks.
	function automatic logic op_hit(input logic valid,
		input mrs_pkg::mrs_op_e code, input mrs_pkg::mrs_op_e want);
		return valid && code == want;
	endfunction : op_hit

	wire is_rrc = op_hit(cmd_valid, cmd.op, mrs_pkg::MRS_OP_RRC);
	wire is_sbi = op_hit(cmd_valid, cmd.op, mrs_pkg::MRS_OP_SBI);
	wire is_sbf = op_hit(cmd_valid, cmd.op, mrs_pkg::MRS_OP_SBF);
	wire is_aux_req = op_hit(cmd_valid, cmd.op, mrs_pkg::MRS_OP_AUX);
	wire is_aux = is_aux_req && aux_addr >= mrs_pkg::SADDR_MIN;
	wire is_halt = op_hit(cmd_valid, cmd.op, mrs_pkg::MRS_OP_HALT);

	// Rotate result and new carry.
	wire [7:0] rrc_res = {flags_ff.c, file_rdata[7:1]};
	wire rrc_c = file_rdata[0];

	// Borrow subtract: a + ~w + c, carry out means no borrow.
	wire [7:0] sb_a = is_sbi ? cmd.imm : file_rdata;
	wire [4:0] sb_lo = {1'b0, sb_a[3:0]} + {1'b0, ~wreg_ff[3:0]}
		+ {4'h0, flags_ff.c};
	wire [8:0] sb_sum = {1'b0, sb_a} + {1'b0, ~wreg_ff}
		+ {8'h00, flags_ff.c};
	wire [7:0] sb_res = sb_sum[7:0];
	wire sb_z = sb_res == 8'h00;
	wire sb_to_w = is_sbi || (is_sbf && cmd.dest == mrs_pkg::DEST_WREG);
	wire rrc_to_w = is_rrc && cmd.dest == mrs_pkg::DEST_WREG;

	wire [7:0] nxt_wreg = rrc_to_w ? rrc_res :
		sb_to_w ? sb_res :
		is_aux ? aux_rdata : wreg_ff;
	wire nxt_fwe = (is_rrc || is_sbf) && cmd.dest != mrs_pkg::DEST_WREG;
	wire [7:0] nxt_fwd = is_rrc ? rrc_res : sb_res;
	mrs_pkg::mrs_flags_s nxt_flags;
	assign nxt_flags = (is_sbi || is_sbf) ?
		{sb_z, sb_lo[4], sb_sum[8]} :
		is_rrc ? {flags_ff.z, flags_ff.dc, rrc_c} : flags_ff;

	always_ff @(posedge clock) begin
		if (srst) begin
			wreg_ff <= mrs_pkg::WREG_RST;
			flags_ff <= mrs_pkg::FLAGS_RST;
			fwe_ff <= 1'b0;
			fwd_ff <= mrs_pkg::FWD_RST;
			wclr_ff <= 1'b0;
			halt_ff <= 1'b0;
			to_ff <= mrs_pkg::TO_RST;
			pd_ff <= mrs_pkg::PD_RST;
		end else begin
			wreg_ff <= nxt_wreg;
			flags_ff <= nxt_flags;
			fwe_ff <= nxt_fwe;
			fwd_ff <= nxt_fwd;
			wclr_ff <= is_halt;
			halt_ff <= halt_ff || is_halt;
			if (is_halt) begin
				to_ff <= 1'b1;
				pd_ff <= 1'b0;
			end
		end
	end

	assign working_register = wreg_ff;
	assign flags = flags_ff;
	assign file_we = fwe_ff;
	assign file_wdata = fwd_ff;
	assign wdt_clear = wclr_ff;
	assign halt_mode = halt_ff;
	assign timeout_status_flag = to_ff;
	assign powerdown_status_flag = pd_ff;

	a_rrc_carry: assert property (@(posedge clock) disable iff (srst)
		is_rrc |=> flags_ff.c == $past(file_rdata[0]))
		else $error("rotate carry wrong");
	a_rrc_wreg: assert property (@(posedge clock) disable iff (srst)
		rrc_to_w |=> wreg_ff == {$past(flags_ff.c), $past(file_rdata[7:1])})
		else $error("rotate result wrong");
	a_rrc_file: assert property (@(posedge clock) disable iff (srst)
		(is_rrc && cmd.dest) |=> file_we && $stable(wreg_ff))
		else $error("rotate write back wrong");
	a_sbi_value: assert property (@(posedge clock) disable iff (srst)
		is_sbi |=> wreg_ff == 8'($past(cmd.imm) + ~$past(wreg_ff)
		+ 8'($past(flags_ff.c)))) else $error("subtract wrong");
	a_sb_zero: assert property (@(posedge clock) disable iff (srst)
		(is_sbi || is_sbf) |=> flags_ff.z == (sb_res_q == 8'h00))
		else $error("zero flag wrong");
	a_aux_flags: assert property (@(posedge clock) disable iff (srst)
		is_aux |=> $stable(flags_ff) && wreg_ff == $past(aux_rdata))
		else $error("aux read wrong");
	a_halt_clear: assert property (@(posedge clock) disable iff (srst)
		is_halt |=> wdt_clear && halt_mode) else $error("halt wrong");
	a_halt_status: assert property (@(posedge clock) disable iff (srst)
		is_halt |=> timeout_status_flag && !powerdown_status_flag)
		else $error("halt status wrong");

	// Registered copy of the subtract result, so the zero flag is checked
	// against the value that was really computed in the issue cycle.
	always_ff @(posedge clock) begin
		if (srst) begin
			sb_res_q <= 8'h00;
		end else begin
			sb_res_q <= sb_res;
		end
	end

	// The flag checks below use a compare form instead of the adder, so a
	// broken carry chain in the datapath cannot hide behind a copy of it.
	a_sb_carry: assert property (
		@(posedge clock) disable iff (srst)
		(is_sbi || is_sbf) |=> flags_ff.c == ($past(flags_ff.c) ?
		($past(sb_a) >= $past(wreg_ff)) : ($past(sb_a) > $past(wreg_ff))))
		else $error("subtract carry wrong");

	a_sb_half: assert property (
		@(posedge clock) disable iff (srst)
		(is_sbi || is_sbf) |=> flags_ff.dc == ($past(flags_ff.c) ?
		($past(sb_a[3:0]) >= $past(wreg_ff[3:0])) :
		($past(sb_a[3:0]) > $past(wreg_ff[3:0]))))
		else $error("subtract half carry wrong");

	a_sbf_value: assert property (
		@(posedge clock) disable iff (srst)
		(is_sbf && !cmd.dest) |=> wreg_ff == 8'($past(file_rdata)
		- $past(wreg_ff) - 8'(!$past(flags_ff.c))))
		else $error("file subtract wrong");

	a_sbf_file: assert property (
		@(posedge clock) disable iff (srst)
		(is_sbf && cmd.dest) |=> file_we && $stable(wreg_ff)
		&& file_wdata == 8'($past(file_rdata) - $past(wreg_ff)
		- 8'(!$past(flags_ff.c))))
		else $error("file subtract write back wrong");

	a_rrc_flags: assert property (
		@(posedge clock) disable iff (srst)
		is_rrc |=> flags_ff.z == $past(flags_ff.z)
		&& flags_ff.dc == $past(flags_ff.dc))
		else $error("rotate touched other flags");

	a_rrc_data: assert property (
		@(posedge clock) disable iff (srst)
		(is_rrc && cmd.dest) |=>
		file_wdata == {$past(flags_ff.c), $past(file_rdata[7:1])})
		else $error("rotate write back data wrong");

	a_file_quiet: assert property (
		@(posedge clock) disable iff (srst)
		!(is_rrc || is_sbf) |=> !file_we)
		else $error("unexpected file write");

	a_aux_refuse: assert property (
		@(posedge clock) disable iff (srst)
		(is_aux_req && aux_addr < mrs_pkg::SADDR_MIN) |=>
		$stable(wreg_ff) && $stable(flags_ff))
		else $error("aux read outside page taken");

	a_idle_hold: assert property (
		@(posedge clock) disable iff (srst)
		!cmd_valid |=> $stable(wreg_ff) && $stable(flags_ff))
		else $error("state moved while idle");

	a_halt_sticky: assert property (
		@(posedge clock) disable iff (srst)
		halt_mode |=> halt_mode)
		else $error("halt mode left");

	a_wclr_only: assert property (
		@(posedge clock) disable iff (srst)
		!is_halt |=> !wdt_clear)
		else $error("watchdog clear without halt");

	a_halt_keep: assert property (
		@(posedge clock) disable iff (srst)
		is_halt |=> $stable(wreg_ff) && $stable(flags_ff))
		else $error("halt changed datapath");

	a_pd_fall: assert property (
		@(posedge clock) disable iff (srst)
		$fell(powerdown_status_flag) |-> $past(is_halt))
		else $error("power down flag cleared without halt");

	a_status_hold: assert property (
		@(posedge clock) disable iff (srst)
		!is_halt |=> $stable(timeout_status_flag)
		&& $stable(powerdown_status_flag))
		else $error("status flags moved without halt");
endmodule : mrs_exec

// ==== tb/mrs_exec_tb.sv ====
`timescale 1ns/1ps
module mrs_exec_tb;
	logic clock = 0, srst = 1, cmd_valid = 0, we, fw, wc, hm, tof, pdf;
	mrs_pkg::mrs_cmd_s cmd = '0;
	mrs_pkg::mrs_flags_s fl, ef = '0;
	mrs_pkg::mrs_op_e ops [5] = '{mrs_pkg::MRS_OP_RRC, mrs_pkg::MRS_OP_SBI,
		mrs_pkg::MRS_OP_SBF, mrs_pkg::MRS_OP_AUX, mrs_pkg::MRS_OP_NONE};
	logic [7:0] fr = 8'h00, ar = 8'h00, wr, fd, ew = 8'h00, r;
	logic [3:0] aa = 4'h0;
	logic [8:0] s;
	logic [4:0] h;
	int err_count = 0, compares = 0, seed = 32'h05d2f7c9;
	always #20 clock = ~clock;
	mrs_exec mrs_exec_inst (.clock(clock), .srst(srst), .cmd_valid(cmd_valid),
		.cmd(cmd), .file_rdata(fr), .aux_rdata(ar), .aux_addr(aa),
		.working_register(wr), .flags(fl), .file_we(fw), .file_wdata(fd),
		.wdt_clear(wc), .halt_mode(hm), .timeout_status_flag(tof),
		.powerdown_status_flag(pdf));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task run(input mrs_pkg::mrs_op_e op, input logic d, input logic [7:0] i);
		cmd = {op, d, i};
		cmd_valid = 1;
		we = 0;
		r = (op == mrs_pkg::MRS_OP_SBI) ? i : fr;
		s = {1'b0, r} + {1'b0, ~ew} + ef.c;
		h = {1'b0, r[3:0]} + {1'b0, ~ew[3:0]} + ef.c;
		case (op)
			mrs_pkg::MRS_OP_RRC: begin
				r = {ef.c, fr[7:1]};
				ef.c = fr[0];
			end
			mrs_pkg::MRS_OP_SBI, mrs_pkg::MRS_OP_SBF: begin
				r = s[7:0];
				ef = '{r == 8'h00, h[4], s[8]};
			end
			mrs_pkg::MRS_OP_AUX: if (aa >= 4'h7) ew = ar;
			default: ;
		endcase
		if (op == mrs_pkg::MRS_OP_RRC || op == mrs_pkg::MRS_OP_SBF) begin
			if (d) we = 1;
			else ew = r;
		end
		if (op == mrs_pkg::MRS_OP_SBI) ew = r;
		@(posedge clock);
		#1;
		chk(wr, ew);
		chk({5'h00, fl}, {5'h00, ef});
		chk({7'h00, fw}, {7'h00, we});
		if (we) chk(fd, r);
		chk({7'h00, wc}, {7'h00, op == mrs_pkg::MRS_OP_HALT});
	endtask : run
	task wrap_up;
		$display("err_count %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (12) @(posedge clock);
		#1 srst = 0;
		chk({tof, pdf, hm, wc}, 8'h0C);
		aa = 4'h7;
		ar = 8'h05;
		run(mrs_pkg::MRS_OP_AUX, 0, 8'h00);
		run(mrs_pkg::MRS_OP_SBI, 0, 8'h06);
		aa = 4'h3;
		run(mrs_pkg::MRS_OP_AUX, 0, 8'h00);
		repeat (300) begin
			fr = $random(seed);
			ar = $random(seed);
			aa = $random(seed);
			run(ops[$unsigned($random(seed)) % 5], $random(seed), $random(seed));
		end
		run(mrs_pkg::MRS_OP_HALT, 0, 8'h00);
		cmd_valid = 0;
		@(posedge clock);
		#1 chk({tof, pdf, hm, wc}, 8'h0A);
		wrap_up();
	end
endmodule : mrs_exec_tb
